// *** logic/iism_defs.svh ***
`ifndef IISM_DEFS_SVH
`define IISM_DEFS_SVH

// Register byte addresses.
`define IISM_ADDR_DATA_CMD   32'h5000_1310
`define IISM_ADDR_MASKED     32'h5000_132c
`define IISM_ADDR_MASK       32'h5000_1330
`define IISM_ADDR_RAW        32'h5000_1334
`define IISM_ADDR_RX_TL      32'h5000_1338
`define IISM_ADDR_TX_TL      32'h5000_133c
`define IISM_ADDR_CLR_ALL    32'h5000_1340
`define IISM_ADDR_CLR_RDREQ  32'h5000_1350
`define IISM_ADDR_CLR_ABRT   32'h5000_1354
`define IISM_ADDR_CLR_ACT    32'h5000_135c
`define IISM_ADDR_CLR_GC     32'h5000_1368
`define IISM_ADDR_ENABLE     32'h5000_136c
`define IISM_ADDR_ABRT_SRC   32'h5000_1380

// Status bit positions, shared by mask, raw and masked status; the last two are bit positions in the clear and enable registers.
`define IISM_B_GC        11
`define IISM_B_START     10
`define IISM_B_STOP      9
`define IISM_B_ACT       8
`define IISM_B_RXDONE    7
`define IISM_B_ABRT      6
`define IISM_B_RDREQ     5
`define IISM_B_TXEMPTY   4
`define IISM_B_TXOVER    3
`define IISM_B_RXFULL    2
`define IISM_B_RXOVER    1
`define IISM_B_RXUNDER   0
`define IISM_B_CLR       0
`define IISM_B_EN        0

// Reset values and sizes.
`define IISM_MASK_RST    12'h8ff
`define IISM_RAW_RST     12'h000
`define IISM_STICKY      12'hfeb
`define IISM_TL_RST      5'h00
`define IISM_SRC_RST     16'h0000
`define IISM_EN_RST      1'h0
`define IISM_FIFO_DEPTH  6'h20
`define IISM_FIFO_EMPTY  6'h00

`endif

// *** logic/iism_pkg.sv ***
`include "iism_defs.svh"

package iism_pkg;

	typedef struct packed {
		logic [11:0] mask;
		logic [11:0] raw;
		logic [15:0] abrt_src;
		logic        en;
		logic [4:0]  tx_tl;
		logic [4:0]  rx_tl;
		logic        scl_q;
		logic        sda_q;
		logic [15:0] rdata;
		logic        push;
		logic [7:0]  wdata;
	} iism_state_t;

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} iism_sync_t;

endpackage

// *** logic/iism_sync_if.sv ***
`timescale 1ns/1ps

interface iism_sync_if;
	logic [1:0] pin_raw;
	logic [1:0] pin_sync;

	modport src
	(
		input  pin_raw,
		output pin_sync
	);

	modport dst
	(
		output pin_raw,
		input  pin_sync
	);
endinterface

// *** logic/iism_sync.sv ***
`timescale 1ns/1ps

module iism_sync
	import iism_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Pins in, synchronised levels out
	iism_sync_if.src  sif
);

	iism_sync_t st_ff;
	iism_sync_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (ce)
		begin
			nxt_st.meta = sif.pin_raw;
			nxt_st.sync = st_ff.meta;
		end
	end

	// An idle bus floats high, so both stages start high to avoid a false edge.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_ff <= '1;
		else
			st_ff <= nxt_st;
	end

	assign sif.pin_sync = st_ff.sync;

endmodule

// *** logic/iism_top.sv ***
`timescale 1ns/1ps

// How it works
// RULE1: Twelve mask bits, reset pattern 0x8ff.
// RULE2: Masked status is raw AND mask; OR drives irq.
// RULE3: General call bit sets on acknowledged call.
// RULE4: General call holds until disable or clear read.
// RULE5: Acknowledged general call data goes to receive buffer.
// RULE6: Start or restart on bus sets bit ten.
// RULE7: Stop on bus sets bit nine.
// RULE8: Activity sticks until disable, clear reads, reset.
// RULE9: Slave transmit not acknowledged sets bit seven.
// RULE10: Transmit abort sets bit six, reason recorded.
// RULE11: Abort flushes transmit FIFO until abort clear read.
// RULE12: Read request sets bit five, holds clock low.
// RULE13: Processor answers read request via data command.
// RULE14: Read request clear read drops bit five.
// RULE15: Transmit empty tracks level against threshold.
// RULE16: Disabled: flushed; empty shows state machine activity.
// RULE17: Command write at 32 entries sets overflow.
// RULE18: Overflow holds until internal enable falls.
// RULE19: Receive full, overflow, underflow on bits two-zero.
module iism_top
	import iism_pkg::*;
(
	// Clock, reset and clock enable
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Processor register port
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// I2C pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	// Protocol engine events and state
	input  wire logic        gc_ack_evt,
	input  wire logic        activity_in,
	input  wire logic        slv_tx_nack_evt,
	input  wire logic        abort_evt,
	input  wire logic [15:0] abort_reason_in,
	input  wire logic        rd_req_evt,
	input  wire logic        rx_byte_evt,
	input  wire logic        sm_active,
	input  wire logic        internal_enable,
	// FIFO side
	input  wire logic [5:0]  tx_level,
	input  wire logic [5:0]  rx_level,
	input  wire logic [7:0]  rx_data,
	output logic             tx_push,
	output logic      [7:0]  tx_wdata,
	output logic             tx_flush,
	output logic             rx_pop,
	output logic             gc_rx_store,
	// Interrupt
	output logic             irq
);

	iism_state_t st_ff;
	iism_state_t nxt_st;

	logic [11:0] set_v;
	logic [11:0] clr_v;
	logic [11:0] masked;
	logic [15:0] rd_val;
	logic        mapped;
	logic        rd_acc;
	logic        wr_acc;
	logic        rd_setup;
	logic        scl_s;
	logic        sda_s;
	logic        start_pin;
	logic        stop_pin;
	logic        wr_cmd;
	logic        rd_cmd;

	iism_sync_if sif ();

	assign sif.pin_raw = {scl_in, sda_in};
	assign scl_s       = sif.pin_sync[1];
	assign sda_s       = sif.pin_sync[0];

	iism_sync u_sync
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.sif     (sif.src)
	);

	assign rd_acc   = psel & penable & ~pwrite;
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr_cmd   = wr_acc & (paddr == `IISM_ADDR_DATA_CMD);
	assign rd_cmd   = rd_acc & (paddr == `IISM_ADDR_DATA_CMD);

	// Edges are taken only from the second synchroniser stage and its delayed copy.
	assign start_pin = st_ff.scl_q & scl_s & st_ff.sda_q & ~sda_s;
	assign stop_pin  = st_ff.scl_q & scl_s & ~st_ff.sda_q & sda_s;

	assign masked = st_ff.raw & st_ff.mask; // [RULE2]

	always_comb
	begin
		mapped = 1'b1;
		rd_val = 16'h0000;
		case (paddr)
			`IISM_ADDR_DATA_CMD:  rd_val = {8'h00, rx_data};
			`IISM_ADDR_MASKED:    rd_val = {4'h0, masked};
			`IISM_ADDR_MASK:      rd_val = {4'h0, st_ff.mask};
			`IISM_ADDR_RAW:       rd_val = {4'h0, st_ff.raw};
			`IISM_ADDR_RX_TL:     rd_val = {11'h000, st_ff.rx_tl};
			`IISM_ADDR_TX_TL:     rd_val = {11'h000, st_ff.tx_tl};
			`IISM_ADDR_CLR_ALL:   rd_val = {15'h0000, |(st_ff.raw & `IISM_STICKY)};
			`IISM_ADDR_CLR_RDREQ: rd_val = {15'h0000, st_ff.raw[`IISM_B_RDREQ]};
			`IISM_ADDR_CLR_ABRT:  rd_val = {15'h0000, st_ff.raw[`IISM_B_ABRT]};
			`IISM_ADDR_CLR_ACT:   rd_val = {15'h0000, st_ff.raw[`IISM_B_ACT]};
			`IISM_ADDR_CLR_GC:    rd_val = {15'h0000, st_ff.raw[`IISM_B_GC]};
			`IISM_ADDR_ENABLE:    rd_val = {15'h0000, st_ff.en};
			`IISM_ADDR_ABRT_SRC:  rd_val = st_ff.abrt_src;
			default:              mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		nxt_st = st_ff;
		set_v  = 12'h000;
		clr_v  = 12'h000;

		set_v[`IISM_B_GC]      = gc_ack_evt;                                            // [RULE3]
		set_v[`IISM_B_START]   = start_pin;                                             // [RULE6]
		set_v[`IISM_B_STOP]    = stop_pin;                                              // [RULE7]
		set_v[`IISM_B_ACT]     = activity_in;                                           // [RULE8]
		set_v[`IISM_B_RXDONE]  = slv_tx_nack_evt;                                       // [RULE9]
		set_v[`IISM_B_ABRT]    = abort_evt;                                             // [RULE10]
		set_v[`IISM_B_RDREQ]   = rd_req_evt;                                            // [RULE12]
		set_v[`IISM_B_TXOVER]  = wr_cmd & (tx_level == `IISM_FIFO_DEPTH);              // [RULE17]
		set_v[`IISM_B_RXOVER]  = rx_byte_evt & (rx_level == `IISM_FIFO_DEPTH);         // [RULE19]
		set_v[`IISM_B_RXUNDER] = rd_cmd & (rx_level == `IISM_FIFO_EMPTY);              // [RULE19]

		if (rd_acc && paddr == `IISM_ADDR_CLR_ALL)
			clr_v = `IISM_STICKY;
		if (rd_acc && paddr == `IISM_ADDR_CLR_GC)
			clr_v[`IISM_B_GC] = 1'b1;                                                 // [RULE4]
		if (rd_acc && paddr == `IISM_ADDR_CLR_ACT)
			clr_v[`IISM_B_ACT] = 1'b1;                                                // [RULE8]
		if (rd_acc && paddr == `IISM_ADDR_CLR_ABRT)
			clr_v[`IISM_B_ABRT] = 1'b1;                                               // [RULE11]
		if (rd_acc && paddr == `IISM_ADDR_CLR_RDREQ)
			clr_v[`IISM_B_RDREQ] = 1'b1;                                              // [RULE14]
		// Overflow flags outlive the enable register until the engine reports idle.
		if (!internal_enable)
		begin
			clr_v[`IISM_B_GC]      = 1'b1;                                            // [RULE4]
			clr_v[`IISM_B_ACT]     = 1'b1;                                            // [RULE8]
			clr_v[`IISM_B_TXOVER]  = 1'b1;                                            // [RULE18]
			clr_v[`IISM_B_RXOVER]  = 1'b1;                                            // [RULE19]
			clr_v[`IISM_B_RXUNDER] = 1'b1;                                            // [RULE19]
		end

		if (ce)
		begin
			nxt_st.scl_q = scl_s;
			nxt_st.sda_q = sda_s;
			// A set in the same cycle as its clear wins, so no event is lost.
			nxt_st.raw = ((st_ff.raw & ~clr_v) | set_v) & `IISM_STICKY;
			if (st_ff.en)
				nxt_st.raw[`IISM_B_TXEMPTY] = ({1'b0, st_ff.tx_tl} >= tx_level);      // [RULE15]
			else
				nxt_st.raw[`IISM_B_TXEMPTY] = sm_active;                               // [RULE16]
			nxt_st.raw[`IISM_B_RXFULL] = st_ff.en & (rx_level > {1'b0, st_ff.rx_tl}); // [RULE19]

			if (abort_evt)
				nxt_st.abrt_src = abort_reason_in;                                     // [RULE10]
			else if (clr_v[`IISM_B_ABRT])
				nxt_st.abrt_src = `IISM_SRC_RST;

			// The processor answers a read request through this write.
			nxt_st.push  = wr_cmd & st_ff.en & ~st_ff.raw[`IISM_B_ABRT]
				& (tx_level != `IISM_FIFO_DEPTH);                                      // [RULE11] [RULE13]
			nxt_st.wdata = wr_cmd ? pwdata[7:0] : st_ff.wdata;

			if (wr_acc)
			begin
				case (paddr)
					`IISM_ADDR_MASK:   nxt_st.mask  = pwdata[11:0];                     // [RULE1]
					`IISM_ADDR_RX_TL:  nxt_st.rx_tl = pwdata[4:0];
					`IISM_ADDR_TX_TL:  nxt_st.tx_tl = pwdata[4:0];
					`IISM_ADDR_ENABLE: nxt_st.en    = pwdata[`IISM_B_EN];
					default:           nxt_st.en    = st_ff.en;
				endcase
			end

			if (rd_setup)
				nxt_st.rdata = rd_val;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff.mask     <= `IISM_MASK_RST;                                          // [RULE1]
			st_ff.raw      <= `IISM_RAW_RST;
			st_ff.abrt_src <= `IISM_SRC_RST;
			st_ff.en       <= `IISM_EN_RST;
			st_ff.tx_tl    <= `IISM_TL_RST;
			st_ff.rx_tl    <= `IISM_TL_RST;
			st_ff.scl_q    <= 1'b1;
			st_ff.sda_q    <= 1'b1;
			st_ff.rdata    <= 16'h0000;
			st_ff.push     <= 1'b0;
			st_ff.wdata    <= 8'h00;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign prdata      = {16'h0000, st_ff.rdata};
	assign pready      = 1'b1;
	assign pslverr     = psel & penable & ~mapped;
	assign irq         = |masked;                                                  // [RULE2]
	assign tx_push     = st_ff.push;
	assign tx_wdata    = st_ff.wdata;
	// The FIFO stays flushed while disabled and for as long as an abort is pending.
	assign tx_flush    = ~st_ff.en | st_ff.raw[`IISM_B_ABRT];                       // [RULE11] [RULE16]
	assign rx_pop      = rd_cmd & ce & (rx_level != `IISM_FIFO_EMPTY);
	assign gc_rx_store = st_ff.raw[`IISM_B_GC];                                     // [RULE5]
	// Clock stretching: SCL is pulled low until a clear read drops the read request bit.
	assign scl_out     = 1'b0;
	assign scl_oe_n    = ~st_ff.raw[`IISM_B_RDREQ];                                 // [RULE12]

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_mask_rst;
		$rose(rst_n) |-> st_ff.mask == `IISM_MASK_RST;
	endproperty
	a_mask_rst: assert property (p_mask_rst) else $error("mask reset value wrong"); // [RULE1]

	property p_irq;
		irq == |(st_ff.raw & st_ff.mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq does not match masked status"); // [RULE2]

	property p_gc_set;
		ce && gc_ack_evt |=> st_ff.raw[`IISM_B_GC] && gc_rx_store;
	endproperty
	a_gc_set: assert property (p_gc_set) else $error("general call not recorded"); // [RULE3]

	property p_gc_hold;
		ce && st_ff.raw[`IISM_B_GC] && internal_enable && !rd_acc |=> st_ff.raw[`IISM_B_GC];
	endproperty
	a_gc_hold: assert property (p_gc_hold) else $error("general call dropped early"); // [RULE4]

	property p_start;
		ce && start_pin |=> st_ff.raw[`IISM_B_START];
	endproperty
	a_start: assert property (p_start) else $error("start not recorded"); // [RULE6]

	property p_act_off;
		ce && !internal_enable && !activity_in |=> !st_ff.raw[`IISM_B_ACT];
	endproperty
	a_act_off: assert property (p_act_off) else $error("activity not cleared on disable"); // [RULE8]

	property p_abrt_flush;
		st_ff.raw[`IISM_B_ABRT] |-> tx_flush ##1 !tx_push;
	endproperty
	a_abrt_flush: assert property (p_abrt_flush) else $error("FIFO not flushed during abort"); // [RULE11]

	property p_rdreq_hold;
		ce && rd_req_evt |=> !scl_oe_n && !scl_out;
	endproperty
	a_rdreq_hold: assert property (p_rdreq_hold) else $error("clock not held on read request"); // [RULE12]

	property p_rdreq_clr;
		ce && rd_acc && paddr == `IISM_ADDR_CLR_RDREQ && !rd_req_evt |=> !st_ff.raw[`IISM_B_RDREQ];
	endproperty
	a_rdreq_clr: assert property (p_rdreq_clr) else $error("read request not cleared"); // [RULE14]

	property p_txover;
		ce && wr_cmd && tx_level == `IISM_FIFO_DEPTH && internal_enable |=> st_ff.raw[`IISM_B_TXOVER] && !tx_push;
	endproperty
	a_txover: assert property (p_txover) else $error("transmit overflow missed"); // [RULE17]

	property p_txempty;
		ce && st_ff.en |=> st_ff.raw[`IISM_B_TXEMPTY] == ($past(tx_level) <= $past({1'b0, st_ff.tx_tl}));
	endproperty
	a_txempty: assert property (p_txempty) else $error("transmit empty wrong"); // [RULE15]

	property p_stop;
		ce && stop_pin |=> st_ff.raw[`IISM_B_STOP];
	endproperty
	a_stop: assert property (p_stop) else $error("stop not recorded"); // [RULE7]

	property p_nack;
		ce && slv_tx_nack_evt |=> st_ff.raw[`IISM_B_RXDONE];
	endproperty
	a_nack: assert property (p_nack) else $error("slave transmit end not recorded"); // [RULE9]

	property p_abrt_src;
		ce && abort_evt |=> st_ff.raw[`IISM_B_ABRT] && st_ff.abrt_src == $past(abort_reason_in);
	endproperty
	a_abrt_src: assert property (p_abrt_src) else $error("abort reason not captured"); // [RULE10]

	property p_push;
		ce && wr_cmd && st_ff.en && !st_ff.raw[`IISM_B_ABRT] && tx_level != `IISM_FIFO_DEPTH
			|=> tx_push && tx_wdata == $past(pwdata[7:0]);
	endproperty
	a_push: assert property (p_push) else $error("command byte not pushed"); // [RULE13]

	property p_off_empty;
		ce && !st_ff.en |-> tx_flush ##1 st_ff.raw[`IISM_B_TXEMPTY] == $past(sm_active);
	endproperty
	a_off_empty: assert property (p_off_empty) else $error("disabled transmit empty wrong"); // [RULE16]

	property p_txover_clr;
		ce && !internal_enable && !wr_cmd |=> !st_ff.raw[`IISM_B_TXOVER];
	endproperty
	a_txover_clr: assert property (p_txover_clr) else $error("transmit overflow not cleared"); // [RULE18]

	property p_rxover;
		ce && rx_byte_evt && rx_level == `IISM_FIFO_DEPTH |=> st_ff.raw[`IISM_B_RXOVER];
	endproperty
	a_rxover: assert property (p_rxover) else $error("receive overflow missed"); // [RULE19]

	property p_rxunder;
		ce && rd_cmd && rx_level == `IISM_FIFO_EMPTY |-> !rx_pop ##1 st_ff.raw[`IISM_B_RXUNDER];
	endproperty
	a_rxunder: assert property (p_rxunder) else $error("receive underflow missed"); // [RULE19]

	property p_rxfull;
		ce |=> st_ff.raw[`IISM_B_RXFULL] == ($past(st_ff.en) && ($past(rx_level) > $past({1'b0, st_ff.rx_tl})));
	endproperty
	a_rxfull: assert property (p_rxfull) else $error("receive full wrong"); // [RULE19]

endmodule

// *** verification/iism_bus_peer.sv ***
`timescale 1ns/1ps

module iism_bus_peer
(
	// Trigger from the bench
	go,
	// Open-drain wires as seen by the controller
	scl_oe_n,
	scl_line,
	sda_line
);
	input  wire logic go;
	input  wire logic scl_oe_n;
	output logic      scl_line;
	output logic      sda_line;

	logic scl_drv;
	logic sda_drv;

	// Pull-ups win where nobody pulls low, so the clock stands high between frames.
	assign scl_line = scl_drv & scl_oe_n;
	assign sda_line = sda_drv;

	initial
	begin
		scl_drv = 1'h1;
		sda_drv = 1'h1;
	end

	// One short frame with a 64 ns bus clock: start, one low phase, stop.
	always @(posedge go)
	begin
		#32 sda_drv = 1'h0;
		#32 scl_drv = 1'h0;
		#32 scl_drv = 1'h1;
		// A stretched clock must be waited out before the stop.
		wait (scl_line === 1'h1);
		#32 sda_drv = 1'h1;
	end
endmodule

// *** verification/i2c_interrupt_status_mask_tb.sv ***
`timescale 1ns/1ps
`include "iism_defs.svh"

module i2c_interrupt_status_mask_tb;
	logic        ref_clk, rst_n, ce, psel, penable, pwrite, go;
	logic [31:0] paddr, pwdata, prdata, rv, d, m;
	logic        pready, pslverr, err_q, pop_q, scl_in, sda_in, scl_out, scl_oe_n;
	logic        gc_ack_evt, activity_in, slv_tx_nack_evt, abort_evt, rd_req_evt;
	logic        rx_byte_evt, sm_active, internal_enable;
	logic [15:0] abort_reason_in;
	logic [5:0]  tx_level, rx_level;
	logic [7:0]  rx_data, tx_wdata, last_w;
	logic        tx_push, tx_flush, rx_pop, gc_rx_store, irq;
	logic [4:0]  tl;
	int          errors, checks, cycles, pushes, n0;

	iism_top dut (.ref_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .scl_in, .sda_in, .scl_out, .scl_oe_n, .gc_ack_evt, .activity_in, .slv_tx_nack_evt,
		.abort_evt, .abort_reason_in, .rd_req_evt, .rx_byte_evt, .sm_active, .internal_enable, .tx_level,
		.rx_level, .rx_data, .tx_push, .tx_wdata, .tx_flush, .rx_pop, .gc_rx_store, .irq);
	iism_bus_peer peer (.go(go), .scl_oe_n(scl_oe_n), .scl_line(scl_in), .sda_line(sda_in));

	initial ref_clk = 1'h0;
	always #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		cycles++;
		if (tx_push === 1'h1)
		begin
			pushes++;
			last_w = tx_wdata;
		end
		if (cycles == 20000)
		begin
			errors++;
			test_done();
		end
	end

	function logic exp_irq(input logic [31:0] r, input logic [31:0] k);
		return |(r[11:0] & k[11:0]);
	endfunction

	function logic exp_empty(input logic [5:0] lvl, input logic [4:0] t);
		return lvl <= {1'h0, t};
	endfunction

	task test_done();
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Two-phase access; read data and error are taken at the access edge.
	// An idle cycle follows, so select never falls and rises in one time step.
	task acc(input logic w, input logic [31:0] a, input logic [31:0] v, output logic [31:0] q);
		psel = 1'h1;
		pwrite = w;
		paddr = a;
		pwdata = v;
		cyc(1);
		penable = 1'h1;
		@(posedge ref_clk);
		q = prdata;
		err_q = pslverr;
		pop_q = rx_pop;
		chk(pready, 32'h1);
		#1;
		psel = 1'h0;
		penable = 1'h0;
		cyc(1);
	endtask

	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(2);
		acc(1'h0, `IISM_ADDR_RAW, 32'h0, rv);
	endtask

	initial
	begin
		void'($urandom(32'hbc96cf60));
		{psel, penable, pwrite, go, gc_ack_evt, activity_in, slv_tx_nack_evt, abort_evt} = 8'h00;
		{rd_req_evt, rx_byte_evt, sm_active, rst_n} = 4'h0;
		{paddr, pwdata, abort_reason_in, tx_level, rx_level, rx_data} = 100'h0;
		ce = 1'h1;
		internal_enable = 1'h1;
		cyc(20);
		rst_n = 1'h1;
		acc(1'h0, `IISM_ADDR_MASK, 32'h0, d);
		chk(d, 32'h8ff);
		acc(1'h0, `IISM_ADDR_RAW, 32'h0, d);
		chk(d, 32'h0);
		m = $urandom;
		acc(1'h1, `IISM_ADDR_MASK, m, d);
		acc(1'h0, `IISM_ADDR_MASK, 32'h0, d);
		chk(d, m & 32'hfff);
		pulse(gc_ack_evt);
		chk(rv[11], 1'h1);
		chk(gc_rx_store, 1'h1);
		chk(irq, exp_irq(rv, m));
		acc(1'h0, `IISM_ADDR_MASKED, 32'h0, d);
		chk(d, rv & m & 32'hfff);
		acc(1'h0, `IISM_ADDR_CLR_GC, 32'h0, d);
		pulse(slv_tx_nack_evt);
		chk(rv[11], 1'h0);
		chk(rv[7], 1'h1);
		pulse(gc_ack_evt);
		internal_enable = 1'h0;
		pulse(activity_in);
		chk(rv[11], 1'h0);
		internal_enable = 1'h1;
		pulse(activity_in);
		cyc(3);
		pulse(go);
		cyc(60);
		acc(1'h0, `IISM_ADDR_RAW, 32'h0, rv);
		chk(rv[10:8], 3'h7);
		acc(1'h0, `IISM_ADDR_CLR_ACT, 32'h0, d);
		acc(1'h0, `IISM_ADDR_CLR_ALL, 32'h0, d);
		acc(1'h0, `IISM_ADDR_RAW, 32'h0, rv);
		chk(rv[10:8], 3'h0);
		acc(1'h1, `IISM_ADDR_ENABLE, 32'h1, d);
		abort_reason_in = $urandom;
		pulse(abort_evt);
		chk(rv[6], 1'h1);
		acc(1'h0, `IISM_ADDR_ABRT_SRC, 32'h0, d);
		chk(d, {16'h0, abort_reason_in});
		chk(tx_flush, 1'h1);
		n0 = pushes;
		acc(1'h1, `IISM_ADDR_DATA_CMD, $urandom, d);
		cyc(2);
		chk(pushes, n0);
		acc(1'h0, `IISM_ADDR_CLR_ABRT, 32'h0, d);
		chk(tx_flush, 1'h0);
		pulse(rd_req_evt);
		chk(rv[5], 1'h1);
		chk({scl_oe_n, scl_out}, 2'h0);
		m = $urandom;
		acc(1'h1, `IISM_ADDR_DATA_CMD, m, d);
		cyc(2);
		chk(pushes, n0 + 1);
		chk(last_w, m[7:0]);
		acc(1'h0, `IISM_ADDR_CLR_RDREQ, 32'h0, d);
		pulse(sm_active);
		chk({rv[5], scl_oe_n}, 2'h1);
		tl = $urandom;
		acc(1'h1, `IISM_ADDR_TX_TL, {27'h0, tl}, d);
		for (int i = 0; i < 6; i++)
		begin
			tx_level = (i == 0) ? {1'h0, tl} : (i == 1) ? tl + 6'h1 : 6'($urandom % 33);
			pulse(rx_byte_evt);
			chk(rv[4], exp_empty(tx_level, tl));
		end
		tx_level = 6'h20;
		n0 = pushes;
		acc(1'h1, `IISM_ADDR_DATA_CMD, 32'h5a, d);
		acc(1'h1, `IISM_ADDR_ENABLE, 32'h0, d);
		sm_active = 1'h1;
		pulse(rx_byte_evt);
		chk(pushes, n0);
		chk(rv[4:3], 2'h3);
		chk(tx_flush, 1'h1);
		sm_active = 1'h0;
		internal_enable = 1'h0;
		pulse(rx_byte_evt);
		chk(rv[4:3], 2'h0);
		internal_enable = 1'h1;
		acc(1'h0, `IISM_ADDR_DATA_CMD, 32'h0, d);
		chk(pop_q, 1'h0);
		acc(1'h0, `IISM_ADDR_RAW, 32'h0, rv);
		chk(rv[0], 1'h1);
		rx_level = 6'($urandom % 32) + 6'h1;
		rx_data = 8'($urandom);
		acc(1'h0, `IISM_ADDR_DATA_CMD, 32'h0, d);
		chk(d, {24'h0, rx_data});
		chk(pop_q, 1'h1);
		acc(1'h0, 32'h5000_1300, 32'h0, d);
		chk(err_q, 1'h1);
		chk(d, 32'h0);
		acc(1'h1, `IISM_ADDR_MASK, 32'h0, d);
		cyc(2);
		chk(irq, 1'h0);
		test_done();
	end
endmodule
